// ---- rtl/ots_defines.svh ----
// constants of the overcurrent trip supervisor
`ifndef OTS_DEFINES_SVH
`define OTS_DEFINES_SVH
// clock and time base
`define OTS_CLK_HZ      125000000
`define OTS_MS_HZ       1000
`define OTS_SMP_PER     16
`define OTS_MAINS_50    50
`define OTS_MAINS_60    60
// times in ms, counted on the 1 ms tick
`define OTS_LONG_MS     16'd3000
`define OTS_IDLE_MS     16'd60000
`define OTS_CHOOSE_MS   16'd200
`define OTS_WDOG_MS     16'd100
`define OTS_RPT_MS      8'd250
`define OTS_PULSE_MS    8'd20
`define OTS_BLINK_MS    8'd250
// widths
`define OTS_SW          12
`define OTS_AW          24
`define OTS_NPH         3
`define OTS_FUNC_LAST   3'h7
// register byte offsets
`define OTS_REG_CTRL    6'h00
`define OTS_REG_STAT    6'h04
`define OTS_REG_MASK    6'h08
`define OTS_REG_PICK    6'h0c
`define OTS_REG_DLY     6'h10
`define OTS_REG_MAG1    6'h14
`define OTS_REG_MAG2    6'h18
`define OTS_REG_MAG3    6'h1c
`define OTS_REG_STATE   6'h20
`define OTS_REG_WDOG    6'h24
`define OTS_REG_DISP    6'h28
// control bits
`define OTS_CTRL_PULSE  0
`define OTS_CTRL_EXT    1
`define OTS_CTRL_M60    2
`define OTS_CTRL_TRST   3
// status / mask bits
`define OTS_ST_PICK     0
`define OTS_ST_TRIP     1
`define OTS_ST_WDOG     2
`define OTS_ST_SEL      3
`define OTS_ST_RST      4
// synchronised pin inputs
`define OTS_IN_SEL      0
`define OTS_IN_WAKE     4
`define OTS_IN_LINE     5
`define OTS_IN_CBOPEN   6
`define OTS_IN_AUX      7
// characters
`define OTS_CH_SPACE    8'h20
`define OTS_CH_MINUS    8'h2d
`define OTS_FAULT_MSG   "Internal Fault  "
`define OTS_DISP_LINE   5'h10
`endif

// ---- rtl/ots_pkg.sv ----
// types of the overcurrent trip supervisor
package ots_pkg;
	typedef enum logic [3:0] {
		OTS_OFF    = 4'h1,
		OTS_CHOOSE = 4'h2,
		OTS_BATT   = 4'h4,
		OTS_CT     = 4'h8
	} ots_mode_e;
	typedef logic [2:0][11:0] ots_smp_t;
	typedef struct packed {
		logic     valid;
		ots_smp_t data;
	} ots_adc_s;
	typedef struct packed {
		logic       on;
		logic [4:0] pos;
		logic [7:0] chr;
	} ots_disp_s;
	typedef struct packed {
		logic alarm;
		logic relay;
		logic pulse;
		logic led;
		logic selfsup;
	} ots_trip_s;
	typedef struct packed {
		logic [7:0]               s1;
		logic [7:0]               s2;
		logic [7:0]               s3;
		logic [7:0]               deb;
		logic                     wreq;
		logic [31:0]              rdata;
		logic [2:0]               ctrl;
		logic [4:0]               stat;
		logic [4:0]               mask;
		logic [23:0]              pick;
		logic [15:0]              dly;
		logic                     nvld;
		logic                     nvwr;
		logic [2:0]               func;
		logic [2:0][15:0][11:0]   hist;
		logic [2:0][23:0]         re;
		logic [2:0][23:0]         im;
		logic [2:0][23:0]         mag;
		logic [3:0]               sidx;
		logic [17:0]              sdiv;
		logic                     adcst;
		logic [16:0]              mdiv;
		logic [7:0]               bcnt;
		logic                     blink;
		ots_mode_e                mode;
		logic [15:0]              mcnt;
		logic [15:0]              lcnt;
		logic [15:0]              dcnt;
		logic [15:0]              wcnt;
		logic [7:0]               rcnt;
		logic [31:0][7:0]         dbuf;
		ots_disp_s                disp;
		ots_trip_s                trip_o;
		logic                     trip;
		logic                     flash;
		logic                     wdfault;
		logic                     cpurst;
		logic                     ext;
		logic                     irq;
	} ots_state_s;
endpackage : ots_pkg

// ---- rtl/ots_supervisor.sv ----
// overcurrent trip supervisor: sampling, fourier filter, trip timing, panel
// Operation
// - sample each phase current 16 times per mains period, 800 or 960 Hz.
// - fourier filter extracts fundamental, rejecting harmonics and DC offset.
// - settings live in nonvolatile memory, compared continuously with currents.
// - any phase above pickup raises the alarm at once.
// - trip output energises only after the set delay runs out.
// - while line current is present, watchdog resets processor on failed execution and raises self-supervision alarm.
// - program error replaces display content with internal-fault message.
// - drive two-line display, 16 characters per line.
// - trip makes LED flash; any button press stops the flashing.
// - short select press, released before long time, advances displayed function.
// - select held 3 s resets latched trip functions.
// - panel and display switch off after 1 min without key press.
// - wake button without line current runs the unit from battery.
// - while choosing supply mode show blinking minus, refuse value access.
// - variants missing their extra supply run with base features only.
// - pulse trip output repeats every 250 ms until breaker opens.
`include "ots_defines.svh"
module ots_supervisor #(
	parameter int P_MS_CYC  = `OTS_CLK_HZ / `OTS_MS_HZ,
	parameter int P_SMP_C50 = `OTS_CLK_HZ / (`OTS_MAINS_50 * `OTS_SMP_PER),
	parameter int P_SMP_C60 = `OTS_CLK_HZ / (`OTS_MAINS_60 * `OTS_SMP_PER)
) (
	// clock and reset
	input  wire logic               i_core_clk,
	input  wire logic               i_rstn,
	// avalon-mm slave
	input  wire logic [5:0]         i_avs_address,
	input  wire logic               i_avs_read,
	input  wire logic               i_avs_write,
	input  wire logic [3:0]         i_avs_byteenable,
	input  wire logic [31:0]        i_avs_writedata,
	output logic [31:0]             o_avs_readdata,
	output logic                    o_avs_waitrequest,
	output logic                    o_irq,
	// pins: buttons sel,plus,minus,enter,wake; line current, breaker open, aux supply
	input  wire logic [7:0]         i_pins,
	input  wire logic               i_aux_variant,
	// converter
	input  wire ots_pkg::ots_adc_s  i_adc,
	output logic                    o_adc_start,
	// nonvolatile settings
	input  wire logic [39:0]        i_nv_data,
	output logic [39:0]             o_nv_data,
	output logic                    o_nv_wr,
	// panel, trip and supervision outputs
	output ots_pkg::ots_disp_s      o_disp,
	output ots_pkg::ots_trip_s      o_trip,
	output logic [2:0]              o_func,
	output logic                    o_batt_en,
	output logic                    o_feat_ext,
	output logic                    o_cpu_rst
);
	localparam logic [127:0] FMSG = `OTS_FAULT_MSG;

	ots_pkg::ots_state_s r;
	ots_pkg::ots_state_s n;
	logic [7:0]  press;
	logic [7:0]  rel;
	logic        tick;
	logic        take;
	logic        over;
	logic        acc_ok;
	logic        pnl;
	logic [4:0]  ev;
	logic [31:0] rv;
	logic [31:0] bm;
	logic [31:0] wv;

	// half-wave table, scaled by 64
	function automatic logic signed [7:0] cosq(input logic [3:0] k);
		logic signed [7:0] c;
		c = 8'sh00;
		unique case (k[2:0])
			3'h0: c = 8'sh40;
			3'h1: c = 8'sh3b;
			3'h2: c = 8'sh2d;
			3'h3: c = 8'sh18;
			3'h4: c = 8'sh00;
			3'h5: c = -8'sh18;
			3'h6: c = -8'sh2d;
			3'h7: c = -8'sh3b;
		endcase
		return k[3] ? -c : c;
	endfunction : cosq

	function automatic logic [23:0] absv(input logic [23:0] v);
		return v[23] ? 24'(-v) : v;
	endfunction : absv

	// register readback
	always_comb begin
		rv = 32'h0;
		unique case (i_avs_address)
			`OTS_REG_CTRL:  rv = {29'h0, r.ctrl};
			`OTS_REG_STAT:  rv = {27'h0, r.stat};
			`OTS_REG_MASK:  rv = {27'h0, r.mask};
			`OTS_REG_PICK:  rv = acc_ok ? {8'h0, r.pick} : 32'h0;
			`OTS_REG_DLY:   rv = acc_ok ? {16'h0, r.dly} : 32'h0;
			`OTS_REG_MAG1:  rv = acc_ok ? {8'h0, r.mag[0]} : 32'h0;
			`OTS_REG_MAG2:  rv = acc_ok ? {8'h0, r.mag[1]} : 32'h0;
			`OTS_REG_MAG3:  rv = acc_ok ? {8'h0, r.mag[2]} : 32'h0;
			`OTS_REG_STATE: rv = {19'h0, r.mode, r.func, r.wdfault, r.trip,
				r.trip_o.alarm, r.flash, r.ext, r.nvld};
			default:        rv = 32'h0;
		endcase
	end

	// byte-lane merge of write data
	always_comb begin
		bm = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
			{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
		wv = (rv & ~bm) | (i_avs_writedata & bm);
	end

	// next state of the whole block
	always_comb begin
		logic signed [12:0] d;
		logic signed [20:0] pc;
		logic signed [20:0] ps;
		d  = 13'sh0;
		pc = 21'sh0;
		ps = 21'sh0;
		n  = r;
		ev = 5'h0;
		take   = (i_avs_read | i_avs_write) & ~r.wreq;
		acc_ok = (r.mode != ots_pkg::OTS_CHOOSE);
		pnl    = (r.mode == ots_pkg::OTS_BATT) | (r.mode == ots_pkg::OTS_CT);

		// pin synchroniser; a level counts once stages two and three agree
		n.s1 = i_pins;
		n.s2 = r.s1;
		n.s3 = r.s2;
		for (int b = 0; b < 8; b++) begin
			if (r.s2[b] == r.s3[b]) begin
				n.deb[b] = r.s3[b];
			end
		end
		press = n.deb & ~r.deb;
		rel   = ~n.deb & r.deb;

		// 1 ms tick and blink phase
		tick   = (r.mdiv == 17'(P_MS_CYC - 1));
		n.mdiv = tick ? 17'h0 : r.mdiv + 17'h1;
		if (tick) begin
			n.bcnt = (r.bcnt == `OTS_BLINK_MS - 8'h1) ? 8'h0 : r.bcnt + 8'h1;
			n.blink = (r.bcnt == `OTS_BLINK_MS - 8'h1) ? ~r.blink : r.blink;
		end

		// settings restored from nonvolatile memory after reset
		n.nvwr = 1'b0;
		if (!r.nvld) begin
			n.pick = i_nv_data[39:16];
			n.dly  = i_nv_data[15:0];
			n.nvld = 1'b1;
		end

		// sample clock, 16 per mains period
		// compare with >= so a switch to the shorter period cannot overrun the divider
		n.adcst = 1'b0;
		if (r.sdiv >= (r.ctrl[`OTS_CTRL_M60] ? 18'(P_SMP_C60 - 1) : 18'(P_SMP_C50 - 1))) begin
			n.sdiv  = 18'h0;
			n.adcst = 1'b1;
		end else begin
			n.sdiv = r.sdiv + 18'h1;
		end

		// sliding fourier filter, one bin at the fundamental
		if (i_adc.valid) begin
			for (int p = 0; p < `OTS_NPH; p++) begin
				d  = $signed({i_adc.data[p][11], i_adc.data[p]})
					- $signed({r.hist[p][r.sidx][11], r.hist[p][r.sidx]});
				pc = d * cosq(r.sidx);
				ps = d * cosq(r.sidx - 4'h4);
				n.re[p] = r.re[p] + 24'(pc);
				n.im[p] = r.im[p] - 24'(ps);
				n.hist[p][r.sidx] = i_adc.data[p];
			end
			n.sidx = r.sidx + 4'h1;
		end
		over = 1'b0;
		for (int p = 0; p < `OTS_NPH; p++) begin
			n.mag[p] = absv(r.re[p]) + absv(r.im[p]);
			over = over | (r.mag[p] > r.pick);
		end

		// pickup alarm and trip delay
		n.trip_o.alarm = over;
		if (over & ~r.trip_o.alarm) begin
			ev[`OTS_ST_PICK] = 1'b1;
		end
		if (!over) begin
			n.dcnt = 16'h0;
		end else if (tick && !r.trip) begin
			if (r.dcnt >= r.dly) begin
				n.trip  = 1'b1;
				n.flash = 1'b1;
				ev[`OTS_ST_TRIP] = 1'b1;
			end else begin
				n.dcnt = r.dcnt + 16'h1;
			end
		end

		// supply mode and panel time-out
		unique case (r.mode)
			ots_pkg::OTS_OFF: begin
				if (press[`OTS_IN_WAKE]) begin
					n.mode = ots_pkg::OTS_CHOOSE;
					n.mcnt = 16'h0;
				end
			end
			ots_pkg::OTS_CHOOSE: begin
				if (tick) begin
					n.mcnt = r.mcnt + 16'h1;
				end
				if (r.mcnt == `OTS_CHOOSE_MS) begin
					n.mode = n.deb[`OTS_IN_LINE] ? ots_pkg::OTS_CT : ots_pkg::OTS_BATT;
					n.mcnt = 16'h0;
				end
			end
			ots_pkg::OTS_BATT, ots_pkg::OTS_CT: begin
				if (|press) begin
					n.mcnt = 16'h0;
				end else if (r.mcnt == `OTS_IDLE_MS) begin
					n.mode = ots_pkg::OTS_OFF;
				end else if (tick) begin
					n.mcnt = r.mcnt + 16'h1;
				end
			end
		endcase

		// select / reset button: short press steps, long press resets
		if (|press) begin
			n.flash = 1'b0;
		end
		if (!pnl || press[`OTS_IN_SEL]) begin
			n.lcnt = 16'h0;
		end else if (r.deb[`OTS_IN_SEL] && tick && r.lcnt != `OTS_LONG_MS) begin
			n.lcnt = r.lcnt + 16'h1;
			if (r.lcnt == `OTS_LONG_MS - 16'h1) begin
				n.trip = 1'b0;
				n.dcnt = 16'h0;
				ev[`OTS_ST_RST] = 1'b1;
			end
		end
		if (pnl && rel[`OTS_IN_SEL] && r.lcnt != `OTS_LONG_MS) begin
			n.func = (r.func == `OTS_FUNC_LAST) ? 3'h0 : r.func + 3'h1;
			ev[`OTS_ST_SEL] = 1'b1;
		end

		// repeating trip pulse until breaker opens
		if (r.trip && r.ctrl[`OTS_CTRL_PULSE] && !r.deb[`OTS_IN_CBOPEN]) begin
			if (tick) begin
				n.rcnt = (r.rcnt == `OTS_RPT_MS - 8'h1) ? 8'h0 : r.rcnt + 8'h1;
			end
		end else begin
			n.rcnt = 8'h0;
		end
		n.trip_o.pulse = r.trip && r.ctrl[`OTS_CTRL_PULSE] && !r.deb[`OTS_IN_CBOPEN]
			&& (r.rcnt < `OTS_PULSE_MS);
		n.trip_o.relay = r.trip & ~r.ctrl[`OTS_CTRL_PULSE];
		n.trip_o.led   = r.trip & (~r.flash | r.blink);

		// watchdog over the processor
		n.cpurst = r.cpurst & ~tick;
		if (take && i_avs_write && i_avs_address == `OTS_REG_WDOG) begin
			n.wcnt    = 16'h0;
			n.wdfault = 1'b0;
		end
		// an expiry in the cycle of a kick still raises the fault
		if (tick && r.deb[`OTS_IN_LINE]) begin
			if (r.wcnt == `OTS_WDOG_MS) begin
				n.wcnt    = 16'h0;
				n.cpurst  = 1'b1;
				n.wdfault = 1'b1;
				ev[`OTS_ST_WDOG] = 1'b1;
			end else begin
				n.wcnt = n.wcnt + 16'h1; // a kick in this cycle restarts from zero
			end
		end
		n.trip_o.selfsup = r.wdfault;

		// base feature set when the extra supply is missing
		n.ext = r.ctrl[`OTS_CTRL_EXT] & (~i_aux_variant | r.deb[`OTS_IN_AUX]);

		// display scan, one character per cycle over both lines
		n.disp.pos = r.disp.pos + 5'h1;
		n.disp.on  = (r.mode != ots_pkg::OTS_OFF);
		if (r.wdfault) begin
			n.disp.chr = (r.disp.pos < `OTS_DISP_LINE)
				? FMSG[8 * (15 - r.disp.pos[3:0]) +: 8] : `OTS_CH_SPACE;
		end else if (r.mode == ots_pkg::OTS_CHOOSE) begin
			n.disp.chr = (r.disp.pos == 5'h0 && r.blink) ? `OTS_CH_MINUS : `OTS_CH_SPACE;
		end else if (r.mode == ots_pkg::OTS_OFF) begin
			n.disp.chr = `OTS_CH_SPACE;
		end else begin
			n.disp.chr = r.dbuf[r.disp.pos];
		end

		// bus: one wait cycle, action at the edge where waitrequest is low
		n.wreq = ~((i_avs_read | i_avs_write) & r.wreq);
		if (i_avs_read && r.wreq) begin
			n.rdata = rv;
		end
		if (take && i_avs_write) begin
			unique case (i_avs_address)
				`OTS_REG_CTRL: begin
					n.ctrl = wv[2:0];
					if (wv[`OTS_CTRL_TRST]) begin
						n.trip = 1'b0;
						n.dcnt = 16'h0;
					end
				end
				`OTS_REG_MASK: n.mask = wv[4:0];
				`OTS_REG_PICK: begin
					if (acc_ok) begin
						n.pick = wv[23:0];
						n.nvwr = 1'b1;
					end
				end
				`OTS_REG_DLY: begin
					if (acc_ok) begin
						n.dly  = wv[15:0];
						n.nvwr = 1'b1;
					end
				end
				`OTS_REG_DISP: begin
					if (acc_ok) begin
						n.dbuf[wv[12:8]] = wv[7:0];
					end
				end
				default: n.ctrl = r.ctrl;
			endcase
		end

		// a trip falling due in the cycle of a reset or key press still latches
		if (ev[`OTS_ST_TRIP]) begin
			n.trip  = 1'b1;
			n.flash = 1'b1;
		end

		// sticky status: read clears what was reported, a new event wins
		if (take && i_avs_read && i_avs_address == `OTS_REG_STAT) begin
			n.stat = r.stat & ~r.rdata[4:0];
		end
		n.stat = n.stat | ev;
		n.irq  = |(n.stat & r.mask);
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r      <= '0;
			r.wreq <= 1'b1;
			r.mode <= ots_pkg::OTS_OFF;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state flops, battery enable decoded from the mode
	assign o_avs_readdata    = r.rdata;
	assign o_avs_waitrequest = r.wreq;
	assign o_irq             = r.irq;
	assign o_adc_start       = r.adcst;
	assign o_nv_data         = {r.pick, r.dly};
	assign o_nv_wr           = r.nvwr;
	assign o_disp            = r.disp;
	assign o_trip            = r.trip_o;
	assign o_func            = r.func;
	assign o_batt_en         = (r.mode == ots_pkg::OTS_BATT);
	assign o_feat_ext        = r.ext;
	assign o_cpu_rst         = r.cpurst;
endmodule : ots_supervisor

// ---- tb/ots_sup_chk_assertions.sv ----
// port checker of the overcurrent trip supervisor
module ots_sup_chk #(
	parameter int P_MS_CYC = 125000
) (
	// clock and reset
	input wire logic               i_core_clk,
	input wire logic               i_rstn,
	// bus strobes and pins
	input wire logic               i_avs_read,
	input wire logic               i_avs_write,
	input wire logic               o_avs_waitrequest,
	input wire logic [7:0]         i_pins,
	// observed outputs
	input wire logic               o_nv_wr,
	input wire ots_pkg::ots_disp_s o_disp,
	input wire ots_pkg::ots_trip_s o_trip,
	input wire logic               o_cpu_rst
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rst_len_r;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	// length of the processor reset pulse
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) rst_len_r <= 32'h0;
		else rst_len_r <= o_cpu_rst ? rst_len_r + 32'h1 : 32'h0;
	end
	// bus handshake: one wait cycle, one ready cycle
	a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("request not answered after one cycle");
	a_wait_short: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("ready held longer than one cycle");
	a_nv_after_write: assert property (o_nv_wr |-> $past(i_avs_write) || $past(i_avs_write, 2))
		else $error("settings store without a bus write");
	a_disp_step: assert property (o_disp.on && $past(o_disp.on) |-> o_disp.pos == $past(o_disp.pos) + 5'h1)
		else $error("display position did not step");
	a_relay_excl: assert property (!(o_trip.relay && o_trip.pulse))
		else $error("relay and pulse outputs both active");
	a_trip_cause: assert property ($rose(o_trip.relay) |-> $past(o_trip.alarm))
		else $error("relay energised without a prior alarm");
	a_pulse_open: assert property (i_pins[6] [*8] |-> !o_trip.pulse)
		else $error("trip pulse while breaker open");
	a_selfsup_rst: assert property ($rose(o_cpu_rst) |-> ##[0:1] o_trip.selfsup)
		else $error("self supervision alarm missing on watchdog reset");
	a_cpurst_len: assert property (rst_len_r <= P_MS_CYC)
		else $error("processor reset longer than one tick");
endmodule : ots_sup_chk
bind ots_supervisor ots_sup_chk #(.P_MS_CYC(P_MS_CYC)) i_ots_sup_chk (
	.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .i_pins(i_pins),
	.o_nv_wr(o_nv_wr), .o_disp(o_disp), .o_trip(o_trip), .o_cpu_rst(o_cpu_rst)
);

// ---- tb/ots_operator.sv ----
// front-panel operator: holds buttons and reads the display back
module ots_operator (
	// clock and display
	input  wire logic               i_clk,
	input  wire ots_pkg::ots_disp_s i_disp,
	// buttons and rebuilt screen
	output logic [4:0]              o_keys,
	output logic [31:0][7:0]        o_screen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] pos_r;
	initial o_keys = 5'h0;
	// rebuild the screen, chr trails pos by one cycle
	always @(posedge i_clk) begin
		pos_r <= i_disp.pos;
		if (i_disp.on) o_screen[pos_r] <= i_disp.chr;
	end
	// hold one button for n cycles, released buttons read low
	task automatic press(input int k, input int n);
		@(posedge i_clk);
		o_keys[k] <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_keys[k] <= 1'b0;
	endtask : press
endmodule : ots_operator

// ---- tb/test_ots_supervisor.sv ----
// self-checking bench of the overcurrent trip supervisor
`include "ots_defines.svh"
module test_ots_supervisor;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [127:0] FMSG = `OTS_FAULT_MSG;
	logic               clk;
	logic               rstn;
	logic [5:0]         addr;
	logic               rd_s;
	logic               wr_s;
	logic [31:0]        wdat;
	logic [31:0]        rdat;
	logic               wreq;
	logic               irq;
	logic [2:0]         env;
	logic [4:0]         keys;
	logic               strap;
	ots_pkg::ots_adc_s  adc;
	logic               adc_go;
	logic [39:0]        nv_o;
	logic               nv_wr;
	ots_pkg::ots_disp_s disp;
	ots_pkg::ots_trip_s trip;
	logic [2:0]         func;
	logic               batt;
	logic               fext;
	logic               crst;
	logic [31:0][7:0]   scr;
	logic [31:0]        exp_q[$];
	logic [31:0]        lfsr;
	logic               ac;
	logic [3:0]         ph;
	int                 fails;
	int                 samples_checked;
	int                 cyc;
	int                 t;
	ots_supervisor #(.P_MS_CYC(10), .P_SMP_C50(20), .P_SMP_C60(16)) i_ots_supervisor (
		.i_core_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd_s),
		.i_avs_write(wr_s), .i_avs_byteenable(4'hf), .i_avs_writedata(wdat),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_irq(irq),
		.i_pins({env, keys}), .i_aux_variant(strap), .i_adc(adc), .o_adc_start(adc_go),
		.i_nv_data(40'h0000400032), .o_nv_data(nv_o), .o_nv_wr(nv_wr), .o_disp(disp),
		.o_trip(trip), .o_func(func), .o_batt_en(batt), .o_feat_ext(fext), .o_cpu_rst(crst)
	);
	ots_operator i_ots_operator (.i_clk(clk), .i_disp(disp), .o_keys(keys), .o_screen(scr));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] step(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : step
	function automatic logic sig(input int k);
		case (k)
			0: return trip.alarm;
			1: return trip.relay;
			2: return trip.pulse;
			3: return batt;
			4: return trip.led;
			5: return fext;
			default: return crst;
		endcase
	endfunction : sig
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic end_sim();
		$display("compared %0d, mismatched %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr_s <= w;
		rd_s <= ~w;
		@(posedge clk);
		while (wreq) @(posedge clk);
		wr_s <= 1'b0;
		rd_s <= 1'b0;
	endtask : bus
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic till(input int k, input logic v, input int n);
		t = 0;
		while (sig(k) !== v && t < n) begin
			@(posedge clk);
			t++;
		end
		chk({31'h0, sig(k)}, {31'h0, v});
	endtask : till
	task automatic keep(input int k, input logic v, input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			@(posedge clk);
			if (sig(k) !== v) bad = 1'b1;
		end
		chk({31'h0, bad}, 32'h0);
	endtask : keep
	// measure cycles between two converter starts
	task automatic per(input int p);
		repeat (40) @(posedge clk);
		while (!adc_go) @(posedge clk);
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (!adc_go && t < 99);
		chk(t, p);
	endtask : per
	// compare each completed read with the oldest note
	always @(posedge clk) begin
		if (rd_s && !wreq) chk(rdat, exp_q.pop_front());
	end
	// converter answers each start: square wave or random dc
	always @(posedge clk) begin
		adc.valid <= adc_go;
		if (adc_go) begin
			ph <= ph + 4'h1;
			adc.data <= ac ? {3{ph[3] ? 12'hf00 : 12'h100}} : {lfsr[3:0], lfsr};
		end
	end
	// cut a hung run short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		rstn = 1'b0;
		addr = 6'h0;
		rd_s = 1'b0;
		wr_s = 1'b0;
		wdat = 32'h0;
		env = 3'h0;
		strap = 1'b1;
		ac = 1'b0;
		ph = 4'h0;
		adc = '0;
		cyc = 0;
		fails = 0;
		samples_checked = 0;
		lfsr = step(32'h3550);
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		// reset values, unmapped place, loaded settings
		rd(`OTS_REG_CTRL, 32'h0);
		rd(`OTS_REG_MASK, 32'h0);
		rd(6'h3c, 32'h0);
		rd(`OTS_REG_PICK, 32'h40);
		rd(`OTS_REG_DLY, 32'h32);
		per(20);
		bus(1'b1, `OTS_REG_CTRL, 32'h4);
		per(16);
		bus(1'b1, `OTS_REG_CTRL, 32'h0);
		bus(1'b1, `OTS_REG_PICK, 32'h30);
		repeat (3) @(posedge clk);
		chk({8'h0, nv_o[39:16]}, 32'h30);
		// dc input gives no fundamental
		repeat (400) @(posedge clk);
		for (int i = 0; i < 3; i++) rd(6'(`OTS_REG_MAG1 + 6'h4 * i), 32'h0);
		// filter fill after reset saw the dc step as a pickup
		rd(`OTS_REG_STAT, 32'h1);
		keep(0, 1'b0, 10);
		// wake without line current, choose then battery
		i_ots_operator.press(4, 20);
		repeat (20) @(posedge clk);
		rd(`OTS_REG_PICK, 32'h0);
		till(3, 1'b1, 2100);
		rd(`OTS_REG_PICK, 32'h30);
		i_ots_operator.press(0, 100);
		repeat (10) @(posedge clk);
		chk({29'h0, func}, 32'h1);
		rd(`OTS_REG_STAT, 32'h8);
		rd(`OTS_REG_STAT, 32'h0);
		bus(1'b1, `OTS_REG_MASK, 32'h3);
		// pickup dropping before the delay cancels the trip
		ac <= 1'b1;
		till(0, 1'b1, 800);
		repeat (100) @(posedge clk);
		ac <= 1'b0;
		till(0, 1'b0, 400);
		keep(1, 1'b0, 600);
		// full delay then relay, status and interrupt
		ac <= 1'b1;
		till(0, 1'b1, 800);
		keep(1, 1'b0, 480);
		till(1, 1'b1, 60);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rd(`OTS_REG_STAT, 32'h3);
		bus(1'b1, `OTS_REG_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		// led flashes until a button is pressed
		till(4, 1'b0, 2600);
		till(4, 1'b1, 2600);
		i_ots_operator.press(1, 20);
		keep(4, 1'b1, 3000);
		// long select press clears the latched trip
		ac <= 1'b0;
		till(0, 1'b0, 400);
		chk({31'h0, trip.relay}, 32'h1);
		i_ots_operator.press(0, 30020);
		repeat (10) @(posedge clk);
		chk({31'h0, trip.relay}, 32'h0);
		chk({29'h0, func}, 32'h1);
		// pulse trip: 200 cycles high every 2500 until breaker opens
		bus(1'b1, `OTS_REG_CTRL, 32'h1);
		ac <= 1'b1;
		till(2, 1'b1, 1100);
		keep(2, 1'b1, 190);
		till(2, 1'b0, 20);
		keep(2, 1'b0, 2250);
		till(2, 1'b1, 100);
		env <= 3'h2;
		// breaker pin passes the synchroniser first
		repeat (8) @(posedge clk);
		keep(2, 1'b0, 3000);
		// extended features need the extra supply
		bus(1'b1, `OTS_REG_CTRL, 32'h2);
		keep(5, 1'b0, 10);
		env <= 3'h6;
		till(5, 1'b1, 20);
		// watchdog runs out without kicks
		env <= 3'h7;
		till(6, 1'b1, 1100);
		repeat (2) @(posedge clk);
		chk({31'h0, trip.selfsup}, 32'h1);
		repeat (40) @(posedge clk);
		for (int i = 0; i < 16; i++) chk({24'h0, scr[i]}, {24'h0, FMSG[8 * (15 - i) +: 8]});
		// a kick clears the self supervision alarm
		bus(1'b1, `OTS_REG_WDOG, 32'h0);
		repeat (3) @(posedge clk);
		chk({31'h0, trip.selfsup}, 32'h0);
		end_sim();
	end
endmodule : test_ots_supervisor
